// File: logic/tmc_main_regs.sv
`timescale 1ns/100ps
// Functional notes
// (R1) reads of undefined register addresses return zero
// (R2) writes to undefined addresses change nothing
// (R3) reset loads every register with its default
// (R4) two-bit gain field selects gain 1,2,4,8 in all scanning modes
// (R5) low-power scan limits scanning to selected inputs; lamps keep behaving; here linked lamps follow only inputs in lowPowerSel
// (R6) inputs dropped by low-power scan flag one release, then stay untouched
// (R7) deep sleep stops scanning, idles lamps, stops pulse-width modulation
// (R8) wake pin driven high clears deep sleep
// (R9) interrupt flag set drives the active-low host interrupt pin
// (R10) touch on input without interrupt enable causes no interrupt action
// (R11) host writes zero to clear flag; pin, wake and ended status drop
// (R12) wake pin not driven while four-wire serial mode is used
// (R13) entering deep sleep clears all status and the interrupt flag
// (R14) lamp summary bit is OR of lamp-done bits
// (R15) power-up flag set after reset, raises interrupt, clears with it
// (R16) many-touch block flag reports suppression, never raises interrupt
// (R17) pattern flag raises interrupt only if enabled; holds until condition ends
// (R18) touch summary bit is OR of six per-input bits
// (R19) per-input bits 5..0 report touch on inputs 6..1
// (R20) per-input bit clears on flag clear only if touch ended; no re-interrupt
// (R21) input 1 may drive lamp 1, input 2 may drive lamp 2
// (R22) lamp-done bits set when host behaviour ends; ignored if linked
// (R23) writes to read-only status and ident registers are ignored
module tmc_main_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic [tmc_pkg::NUM_INPUTS-1:0] touchRaw,
  input wire logic [tmc_pkg::NUM_INPUTS-1:0] touchIrqEn,
  input wire logic [tmc_pkg::NUM_INPUTS-1:0] lowPowerSel,
  input wire logic manyTouchBlock,
  input wire logic patternHit,
  input wire logic patternIrqEn,
  input wire logic resetPinQualified,
  input wire logic [tmc_pkg::NUM_LAMPS-1:0] lampDonePulse,
  input wire logic [tmc_pkg::NUM_LAMPS-1:0] lampLinked,
  input wire logic wakePinIn,
  input wire logic fourWirePin,
  output logic wakePinOut,
  output logic wakePinOe,
  output logic alertN,
  output tmc_pkg::tmc_gain_e sensGain,
  output logic [tmc_pkg::NUM_INPUTS-1:0] scanMask,
  output logic [tmc_pkg::NUM_INPUTS-1:0] touchRelease,
  output logic [tmc_pkg::NUM_LAMPS-1:0] lampLinkDrive,
  output logic lampIdle,
  output logic pwmHalt
);
  import tmc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic wakeS1;
    logic wakeS2;
    logic fourS1;
    logic fourS2;
    tmc_gain_e gain;
    logic lowPower;
    logic lowPowerPrev;
    logic deepSleep;
    logic intFlag;
    logic [NUM_INPUTS-1:0] touchSt;
    logic [NUM_INPUTS-1:0] touchPrev;
    logic [NUM_INPUTS-1:0] dropPulse;
    logic porDone;
    logic powerUp;
    logic manySt;
    logic patternSt;
    logic patternPrev;
    logic [NUM_LAMPS-1:0] lampSt;
    logic wakeFlag;
    logic [1:0] driveHist;
    logic [7:0] rdData;
  } tmc_state_s;

  tmc_state_s state_r;
  tmc_state_s state_nxt;

  // decode and event terms
  logic wrMain;
  logic mapped;
  logic intClr;
  logic intSetAny;
  logic sleepEnter;
  logic wakeHigh;
  logic lowPowerRise;
  logic [NUM_INPUTS-1:0] liveMask;
  logic [NUM_INPUTS-1:0] effTouch;
  logic [NUM_INPUTS-1:0] newTouch;
  logic touchIrq;
  logic patternIrq;
  logic powerUpSet;
  logic [NUM_LAMPS-1:0] lampSet;
  logic [7:0] genStatus;

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    state_nxt = state_r;
    // pin synchronisers
    state_nxt.wakeS1 = wakePinIn;
    state_nxt.wakeS2 = state_r.wakeS1;
    state_nxt.fourS1 = fourWirePin;
    state_nxt.fourS2 = state_r.fourS1;

    // address decode
    wrMain = regWrEn && (regAddr == MAIN_CONTROL_ADDR); // (R2) (R23)
    mapped = (regAddr == MAIN_CONTROL_ADDR) || (regAddr == GENERAL_STATUS_ADDR) ||
             (regAddr == PER_INPUT_TOUCH_STATUS_ADDR) || (regAddr == LAMP_DONE_STATUS_ADDR) ||
             (regAddr == PART_IDENT_ADDR) || (regAddr == MAKER_IDENT_ADDR) ||
             (regAddr == SILICON_REVISION_ADDR);
    intClr = wrMain && !regWrData[INT_BIT]; // (R11)
    sleepEnter = wrMain && regWrData[DEEP_SLEEP_BIT] && !state_r.deepSleep;
    // own drive of the shared pin, and its echo through the synchroniser, is not a wake request
    state_nxt.driveHist = {state_r.driveHist[0], wakePinOe};
    wakeHigh = state_r.wakeS2 && !state_r.wakeFlag && (state_r.driveHist == 2'h0);

    // inputs still sampled in the current power state
    if (state_r.deepSleep) begin
      liveMask = NO_INPUTS; // (R7)
    end else if (state_r.lowPower) begin
      liveMask = lowPowerSel; // (R5)
    end else begin
      liveMask = ALL_INPUTS;
    end
    effTouch = touchRaw & liveMask; // (R6)
    newTouch = effTouch & ~state_r.touchPrev; // (R20)
    state_nxt.touchPrev = effTouch;

    // one release report for inputs dropped by low-power scan
    lowPowerRise = state_r.lowPower && !state_r.lowPowerPrev;
    state_nxt.lowPowerPrev = state_r.lowPower;
    state_nxt.dropPulse = lowPowerRise ? (state_r.touchPrev & ~lowPowerSel) : NO_INPUTS; // (R6)

    // interrupt sources
    touchIrq = |(newTouch & touchIrqEn); // (R10)
    patternIrq = patternHit && !state_r.patternPrev && patternIrqEn; // (R17)
    powerUpSet = !state_r.porDone || resetPinQualified; // (R15)
    intSetAny = touchIrq || patternIrq || powerUpSet;
    state_nxt.porDone = 1'b1;
    state_nxt.patternPrev = patternHit;

    // per-input status: set wins over clear, lasting touches stay
    state_nxt.touchSt = (intClr ? (state_r.touchSt & effTouch) : state_r.touchSt) | newTouch; // (R19) (R20)

    // power-up flag
    state_nxt.powerUp = (intClr ? 1'b0 : state_r.powerUp) | powerUpSet; // (R15)

    // many-touch flag follows blocking, no interrupt
    state_nxt.manySt = manyTouchBlock && !state_r.deepSleep; // (R16)

    // pattern flag holds until condition gone and flag cleared
    if (patternHit) begin
      state_nxt.patternSt = 1'b1; // (R17)
    end else if (intClr) begin
      state_nxt.patternSt = 1'b0;
    end

    // lamp-done bits ignored while linked
    lampSet = lampDonePulse & ~lampLinked; // (R22)
    state_nxt.lampSt = (intClr ? {NUM_LAMPS{1'b0}} : state_r.lampSt) | lampSet; // (R22)

    // wake output raised by touch during low-power scan
    state_nxt.wakeFlag = (intClr ? 1'b0 : state_r.wakeFlag) | (touchIrq && state_r.lowPower); // (R11)

    // interrupt flag: host write of one sets, zero clears, events win
    if (intSetAny) begin
      state_nxt.intFlag = 1'b1; // (R9)
    end else if (wrMain) begin
      state_nxt.intFlag = regWrData[INT_BIT]; // (R11)
    end

    // control fields
    if (wrMain) begin
      state_nxt.gain = tmc_gain_e'(regWrData[GAIN_HI:GAIN_LO]); // (R4)
      state_nxt.lowPower = regWrData[LOW_POWER_BIT]; // (R5)
      state_nxt.deepSleep = regWrData[DEEP_SLEEP_BIT];
    end else if (wakeHigh && state_r.deepSleep) begin
      state_nxt.deepSleep = 1'b0; // (R8)
    end

    // entering deep sleep wipes all status
    if (sleepEnter) begin
      state_nxt.touchSt = NO_INPUTS; // (R13)
      state_nxt.powerUp = 1'b0;
      state_nxt.manySt = 1'b0;
      state_nxt.patternSt = 1'b0;
      state_nxt.lampSt = {NUM_LAMPS{1'b0}};
      state_nxt.wakeFlag = 1'b0;
      state_nxt.intFlag = 1'b0; // (R13)
    end

    // general status summary
    genStatus = REG_RESET;
    genStatus[GS_LAMP_BIT] = |state_r.lampSt; // (R14)
    genStatus[GS_POWER_UP_BIT] = state_r.powerUp;
    genStatus[GS_MANY_BIT] = state_r.manySt;
    genStatus[GS_PATTERN_BIT] = state_r.patternSt;
    genStatus[GS_TOUCH_BIT] = |state_r.touchSt; // (R18)

    // registered read data, zero for undefined addresses
    if (regRdEn) begin
      unique case (regAddr)
        MAIN_CONTROL_ADDR: begin
          state_nxt.rdData = {state_r.gain, state_r.lowPower, state_r.deepSleep, 3'h0, state_r.intFlag};
        end
        GENERAL_STATUS_ADDR: begin
          state_nxt.rdData = genStatus;
        end
        PER_INPUT_TOUCH_STATUS_ADDR: begin
          state_nxt.rdData = {2'h0, state_r.touchSt}; // (R19)
        end
        LAMP_DONE_STATUS_ADDR: begin
          state_nxt.rdData = {6'h00, state_r.lampSt};
        end
        PART_IDENT_ADDR: begin
          state_nxt.rdData = PART_IDENT_VAL;
        end
        MAKER_IDENT_ADDR: begin
          state_nxt.rdData = MAKER_IDENT_VAL;
        end
        SILICON_REVISION_ADDR: begin
          state_nxt.rdData = SILICON_REVISION_VAL;
        end
        default: begin
          state_nxt.rdData = REG_RESET; // (R1)
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  // all fields take their defaults on reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= '0; // (R3)
    end else begin
      state_r <= state_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  // host and sensing side outputs
  assign regRdData = state_r.rdData;
  assign alertN = !state_r.intFlag; // (R9)
  assign sensGain = state_r.gain; // (R4)
  assign scanMask = liveMask;
  assign touchRelease = state_r.dropPulse; // (R6)
  assign lampIdle = state_r.deepSleep; // (R7)
  assign pwmHalt = state_r.deepSleep; // (R7)
  // linked lamps follow their inputs; in low-power scan only inputs in lowPowerSel
  assign lampLinkDrive = state_r.touchPrev[NUM_LAMPS-1:0] & lampLinked; // (R21) (R5)
  // wake pin driven high only outside four-wire mode
  assign wakePinOut = 1'b1;
  assign wakePinOe = state_r.wakeFlag && !state_r.fourS2; // (R12)

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_host_clear;
    wrMain && !regWrData[INT_BIT] && !intSetAny && !sleepEnter;
  endsequence

  sequence s_sleep_write;
    wrMain && regWrData[DEEP_SLEEP_BIT] && !state_r.deepSleep;
  endsequence

  sequence s_sleep_quiet;
    lampIdle && pwmHalt && (scanMask == NO_INPUTS) && alertN;
  endsequence

  sequence s_low_power_start;
    state_r.lowPower && !state_r.lowPowerPrev;
  endsequence

  a_unmapped_read_zero: assert property (regRdEn && !mapped |=> regRdData == 8'h00) // (R1)
    else $error("undefined address read not zero");

  a_unmapped_write_keeps: assert property (regWrEn && !mapped && !regRdEn // (R2)
      |=> $stable(sensGain) && $stable(state_r.lowPower) && $stable(regRdData))
    else $error("undefined address write changed state");

  a_gain_write_applies: assert property (wrMain |=> sensGain == $past(regWrData[GAIN_HI:GAIN_LO])) // (R4)
    else $error("gain field not taken");

  a_sleep_halts_all: assert property (s_sleep_write |=> s_sleep_quiet) // (R7)
    else $error("deep sleep did not halt activity");

  a_sleep_clears_status: assert property (s_sleep_write ##[1:2] // (R13)
      (regRdEn && regAddr == PER_INPUT_TOUCH_STATUS_ADDR) |=> regRdData == 8'h00)
    else $error("deep sleep left touch status");

  a_wake_ends_sleep: assert property (state_r.deepSleep && wakeHigh && !wrMain |=> !state_r.deepSleep) // (R8)
    else $error("wake pin did not clear deep sleep");

  a_touch_raises_alert: assert property ((|(newTouch & touchIrqEn) && !sleepEnter) ##1 !wrMain // (R9)
      |-> !alertN [*2])
    else $error("enabled touch did not assert alert");

  a_masked_touch_quiet: assert property ($rose(state_r.intFlag) |-> $past(intSetAny) || $past(wrMain)) // (R10) (R16)
    else $error("interrupt raised without enabled source");

  a_clear_drops_alert: assert property (s_host_clear |=> alertN && !wakePinOe) // (R11)
    else $error("flag clear left alert or wake");

  a_fourwire_no_drive: assert property (state_r.fourS2 |-> !wakePinOe) // (R12)
    else $error("wake pin driven in four-wire mode");

  a_lamp_summary_bit: assert property (regRdEn && regAddr == GENERAL_STATUS_ADDR // (R14)
      |=> regRdData[GS_LAMP_BIT] == $past(|state_r.lampSt))
    else $error("lamp summary wrong");

  a_touch_summary_bit: assert property (regRdEn && regAddr == GENERAL_STATUS_ADDR // (R18)
      |=> regRdData[GS_TOUCH_BIT] == $past(|state_r.touchSt))
    else $error("touch summary wrong");

  a_powerup_sets_int: assert property ($rose(state_r.porDone) |-> state_r.powerUp && !alertN) // (R15)
    else $error("power-up flag or interrupt missing");

  a_release_once: assert property (touchRelease != NO_INPUTS |=> touchRelease == NO_INPUTS) // (R6)
    else $error("release reported more than once");

  a_lasting_touch_kept: assert property (s_host_clear ##0 (effTouch[0] && state_r.touchSt[0]) // (R20)
      |=> state_r.touchSt[0] ##0 alertN)
    else $error("lasting touch status lost or re-interrupted");

  a_linked_lamp_ignored: assert property (lampDonePulse[0] && lampLinked[0] && !state_r.lampSt[0] // (R22)
      |=> !state_r.lampSt[0])
    else $error("linked lamp set done bit");

  // flags that must follow their sources
  a_pattern_flag_holds: assert property (patternHit && !sleepEnter |=> state_r.patternSt) // (R17)
    else $error("pattern flag not held");

  a_no_source_quiet: assert property (!state_r.intFlag && !intSetAny && !wrMain |=> alertN) // (R10) (R16)
    else $error("alert without interrupt source");

  a_low_power_mask: assert property (state_r.lowPower && !state_r.deepSleep |-> scanMask == lowPowerSel) // (R5)
    else $error("low-power scan mask wrong");

  a_dropped_release: assert property (s_low_power_start // (R6)
      |=> touchRelease == ($past(state_r.touchPrev) & ~$past(lowPowerSel)))
    else $error("dropped input release wrong");

  a_clear_wipes_flags: assert property (s_host_clear ##0 (lampDonePulse == 2'h0) // (R15) (R22)
      |=> !state_r.powerUp && (state_r.lampSt == 2'h0))
    else $error("flag clear left power-up or lamp status");

  a_sleep_wipes_flags: assert property (s_sleep_write // (R13)
      |=> (state_r.touchSt == NO_INPUTS) && (state_r.lampSt == 2'h0) && !state_r.powerUp && !state_r.patternSt)
    else $error("deep sleep left status flags");

  a_ident_read: assert property (regRdEn && regAddr == PART_IDENT_ADDR |=> regRdData == PART_IDENT_VAL) // (R23)
    else $error("part ident read wrong");

  // echo of our own wake drive must not end deep sleep
  a_wake_echo_ignored: assert property (state_r.deepSleep && (state_r.driveHist != 2'h0) && !wrMain // (R8)
      |=> state_r.deepSleep)
    else $error("own wake drive ended deep sleep");
endmodule : tmc_main_regs

// File: logic/tmc_pkg.sv
package tmc_pkg;
  // register offsets
  localparam logic [7:0] MAIN_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] GENERAL_STATUS_ADDR = 8'h02;
  localparam logic [7:0] PER_INPUT_TOUCH_STATUS_ADDR = 8'h03;
  localparam logic [7:0] LAMP_DONE_STATUS_ADDR = 8'h04;
  localparam logic [7:0] PART_IDENT_ADDR = 8'hFD;
  localparam logic [7:0] MAKER_IDENT_ADDR = 8'hFE;
  localparam logic [7:0] SILICON_REVISION_ADDR = 8'hFF;

  // main control field positions
  localparam int GAIN_HI = 7;
  localparam int GAIN_LO = 6;
  localparam int LOW_POWER_BIT = 5;
  localparam int DEEP_SLEEP_BIT = 4;
  localparam int INT_BIT = 0;

  // general status field positions
  localparam int GS_LAMP_BIT = 4;
  localparam int GS_POWER_UP_BIT = 3;
  localparam int GS_MANY_BIT = 2;
  localparam int GS_PATTERN_BIT = 1;
  localparam int GS_TOUCH_BIT = 0;

  // widths and reset values
  localparam int NUM_INPUTS = 6;
  localparam int NUM_LAMPS = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] GAIN_RESET = 2'h0;
  localparam logic [5:0] ALL_INPUTS = 6'h3F;
  localparam logic [5:0] NO_INPUTS = 6'h00;

  // identification values, arbitrary
  localparam logic [7:0] PART_IDENT_VAL = 8'hA1;
  localparam logic [7:0] MAKER_IDENT_VAL = 8'hB2;
  localparam logic [7:0] SILICON_REVISION_VAL = 8'h01;

  // sensing gain codes
  typedef enum logic [1:0] {TMC_GAIN1, TMC_GAIN2, TMC_GAIN4, TMC_GAIN8} tmc_gain_e;
endpackage : tmc_pkg

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
  import tmc_pkg::*;
  logic core_clk, rst, regWrEn, regRdEn, manyTouchBlock, patternHit, patternIrqEn;
  logic resetPinQualified, wakePinIn, fourWirePin, wakePinOut, wakePinOe, alertN, lampIdle, pwmHalt;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [5:0] touchRaw, touchIrqEn, lowPowerSel, scanMask, touchRelease;
  logic [1:0] lampDonePulse, lampLinked, lampLinkDrive;
  tmc_gain_e sensGain;
  int errTotal, comparisons, cyc, relCnt;

  tmc_host_model host (.core_clk(core_clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData));
  tmc_main_regs dut (.core_clk(core_clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .touchRaw(touchRaw),
    .touchIrqEn(touchIrqEn), .lowPowerSel(lowPowerSel), .manyTouchBlock(manyTouchBlock),
    .patternHit(patternHit), .patternIrqEn(patternIrqEn), .resetPinQualified(resetPinQualified),
    .lampDonePulse(lampDonePulse), .lampLinked(lampLinked), .wakePinIn(wakePinIn),
    .fourWirePin(fourWirePin), .wakePinOut(wakePinOut), .wakePinOe(wakePinOe), .alertN(alertN),
    .sensGain(sensGain), .scanMask(scanMask), .touchRelease(touchRelease),
    .lampLinkDrive(lampLinkDrive), .lampIdle(lampIdle), .pwmHalt(pwmHalt));

  ////////////////////////////////////////////////////////////////
  // clock, hang limit and release pulse counter
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (touchRelease[1] === 1'b1) relCnt++;
    if (cyc == 5000) begin
      errTotal++;
      closeOut();
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks and closing
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  task automatic chkPin(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] %0t pin got %h exp %h", $time, got, exp);
    end
  endtask : chkPin
  task automatic chkReg(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    host.hostRead(addr, got);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] %0t reg %h got %h exp %h", $time, addr, got, exp);
    end
  endtask : chkReg
  task automatic closeOut();
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : closeOut

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    {manyTouchBlock, patternHit, patternIrqEn, resetPinQualified, wakePinIn, fourWirePin} = 6'h00;
    {touchRaw, touchIrqEn} = 12'h000;
    lowPowerSel = 6'h01;
    {lampDonePulse, lampLinked} = 4'h0;
    tick(2);
    chkPin({7'h00, alertN}, 8'h01);
    rst = 1'b0;
    tick(2);
    chkPin({7'h00, alertN}, 8'h00);
    chkReg(GENERAL_STATUS_ADDR, 8'h08);
    chkReg(MAIN_CONTROL_ADDR, 8'h01);
    chkReg(LAMP_DONE_STATUS_ADDR, 8'h00);
    chkReg(PART_IDENT_ADDR, PART_IDENT_VAL);
    chkReg(MAKER_IDENT_ADDR, MAKER_IDENT_VAL);
    chkReg(SILICON_REVISION_ADDR, SILICON_REVISION_VAL);
    host.hostWrite(MAIN_CONTROL_ADDR, 8'h00);
    chkPin({7'h00, alertN}, 8'h01);
    chkReg(GENERAL_STATUS_ADDR, 8'h00);
    // qualified reset pin release raises the power-up flag again
    resetPinQualified = 1'b1;
    tick(1);
    resetPinQualified = 1'b0;
    tick(1);
    chkPin({7'h00, alertN}, 8'h00);
    chkReg(GENERAL_STATUS_ADDR, 8'h08);
    host.hostWrite(MAIN_CONTROL_ADDR, 8'h00);
    chkReg(GENERAL_STATUS_ADDR, 8'h00);
    // read-only and undefined places
    host.hostWrite(8'h01, 8'hFF);
    host.hostWrite(PER_INPUT_TOUCH_STATUS_ADDR, 8'hFF);
    host.hostWrite(PART_IDENT_ADDR, 8'h00);
    chkReg(8'h01, 8'h00);
    chkReg(8'h05, 8'h00);
    chkReg(MAIN_CONTROL_ADDR, 8'h00);
    chkReg(PER_INPUT_TOUCH_STATUS_ADDR, 8'h00);
    chkReg(PART_IDENT_ADDR, PART_IDENT_VAL);
    // every gain code
    for (int g = 0; g < 4; g++) begin
      host.hostWrite(MAIN_CONTROL_ADDR, {g[1:0], 6'h00});
      chkPin({6'h00, sensGain}, {6'h00, g[1:0]});
      chkReg(MAIN_CONTROL_ADDR, {g[1:0], 6'h00});
    end
    host.hostWrite(MAIN_CONTROL_ADDR, 8'h00);
    // touch without enable, then with enable and a lasting touch
    touchRaw = 6'h04;
    tick(2);
    chkPin({7'h00, alertN}, 8'h01);
    chkReg(PER_INPUT_TOUCH_STATUS_ADDR, 8'h04);
    chkReg(GENERAL_STATUS_ADDR, 8'h01);
    touchIrqEn = ALL_INPUTS;
    lampLinked = 2'b01;
    touchRaw = 6'h05;
    tick(3);
    chkPin({7'h00, alertN}, 8'h00);
    chkPin({6'h00, lampLinkDrive}, 8'h01);
    host.hostWrite(MAIN_CONTROL_ADDR, 8'h00);
    tick(2);
    chkPin({7'h00, alertN}, 8'h01);
    chkReg(PER_INPUT_TOUCH_STATUS_ADDR, 8'h05);
    touchRaw = 6'h00;
    lampLinked = 2'b00;
    host.hostWrite(MAIN_CONTROL_ADDR, 8'h00);
    chkReg(PER_INPUT_TOUCH_STATUS_ADDR, 8'h00);
    // lamp finished
    lampLinked = 2'b01;
    lampDonePulse = 2'b11;
    tick(1);
    lampDonePulse = 2'b00;
    lampLinked = 2'b00;
    chkReg(LAMP_DONE_STATUS_ADDR, 8'h02);
    chkReg(GENERAL_STATUS_ADDR, 8'h10);
    host.hostWrite(MAIN_CONTROL_ADDR, 8'h00);
    chkReg(LAMP_DONE_STATUS_ADDR, 8'h00);
    // many-touch block and pattern flags
    manyTouchBlock = 1'b1;
    tick(2);
    chkReg(GENERAL_STATUS_ADDR, 8'h04);
    chkPin({7'h00, alertN}, 8'h01);
    manyTouchBlock = 1'b0;
    patternHit = 1'b1;
    tick(2);
    chkPin({7'h00, alertN}, 8'h01);
    patternHit = 1'b0;
    host.hostWrite(MAIN_CONTROL_ADDR, 8'h00);
    patternIrqEn = 1'b1;
    patternHit = 1'b1;
    tick(2);
    chkPin({7'h00, alertN}, 8'h00);
    host.hostWrite(MAIN_CONTROL_ADDR, 8'h00);
    chkReg(GENERAL_STATUS_ADDR, 8'h02);
    patternHit = 1'b0;
    host.hostWrite(MAIN_CONTROL_ADDR, 8'h00);
    chkReg(GENERAL_STATUS_ADDR, 8'h00);
    // low-power scan drops input 2 while it is touched
    touchIrqEn = NO_INPUTS;
    touchRaw = 6'h02;
    tick(2);
    relCnt = 0;
    host.hostWrite(MAIN_CONTROL_ADDR, 8'h20);
    tick(4);
    chkPin({2'h0, scanMask}, 8'h01);
    chkPin(relCnt[7:0], 8'h01);
    touchIrqEn = ALL_INPUTS;
    touchRaw = 6'h03;
    tick(3);
    chkPin({6'h00, wakePinOe, wakePinOut}, 8'h03);
    host.hostWrite(MAIN_CONTROL_ADDR, 8'h20);
    chkPin({7'h00, wakePinOe}, 8'h00);
    fourWirePin = 1'b1;
    touchRaw = 6'h00;
    tick(3);
    touchRaw = 6'h01;
    tick(3);
    chkPin({6'h00, wakePinOe, alertN}, 8'h00);
    // deep sleep entry with a pending flag, then wake
    host.hostWrite(MAIN_CONTROL_ADDR, 8'h10);
    tick(1);
    chkPin({4'h0, alertN, lampIdle, pwmHalt, |scanMask}, 8'h0E);
    chkReg(PER_INPUT_TOUCH_STATUS_ADDR, 8'h00);
    chkReg(MAIN_CONTROL_ADDR, 8'h10);
    touchRaw = 6'h00;
    fourWirePin = 1'b0;
    wakePinIn = 1'b1;
    tick(5);
    wakePinIn = 1'b0;
    chkReg(MAIN_CONTROL_ADDR, 8'h00);
    closeOut();
  end
endmodule : tb

// File: tb/tmc_host_model.sv
`timescale 1ns/100ps
// host side of the parallel register port; strobes last one cycle
module tmc_host_model (
  input wire logic core_clk,
  output logic regWrEn,
  output logic regRdEn,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData
);
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  // write; a zero in the flag bit is how the host clears it
  task automatic hostWrite(input logic [7:0] addr, input logic [7:0] data);
    @(negedge core_clk);
    regWrEn = 1'b1;
    regAddr = addr;
    regWrData = data;
    @(negedge core_clk);
    regWrEn = 1'b0;
    regAddr = ~addr; // stale bus lines never keep the old value
    regWrData = ~data;
  endtask : hostWrite
  // read; data is registered, so it is taken one cycle after the strobe
  task automatic hostRead(input logic [7:0] addr, output logic [7:0] data);
    @(negedge core_clk);
    regRdEn = 1'b1;
    regAddr = addr;
    @(negedge core_clk);
    regRdEn = 1'b0;
    regAddr = ~addr;
    data = regRdData;
  endtask : hostRead
endmodule : tmc_host_model
